// file: design/sac_ctrl.sv
`include "sac_map.svh"

module sac_ctrl
    import sac_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        CE_IN,
    input  wire logic [11:0] AWADDR_IN,
    input  wire logic        AWVALID_IN,
    output logic             AWREADY_OUT,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic [3:0]  WSTRB_IN,
    input  wire logic        WVALID_IN,
    output logic             WREADY_OUT,
    output logic [1:0]       BRESP_OUT,
    output logic             BVALID_OUT,
    input  wire logic        BREADY_IN,
    input  wire logic [11:0] ARADDR_IN,
    input  wire logic        ARVALID_IN,
    output logic             ARREADY_OUT,
    output logic [31:0]      RDATA_OUT,
    output logic [1:0]       RRESP_OUT,
    output logic             RVALID_OUT,
    input  wire logic        RREADY_IN,
    input  wire logic        CMP_HIGH_IN,
    output logic [9:0]       DAC_CODE_OUT,
    output logic             SAMPLE_HOLD_OUT,
    output logic [2:0]       CHANNEL_OUT,
    output logic [7:0]       ANALOG_PINS_OUT,
    output logic [1:0]       REF_SEL_OUT,
    output logic             POWER_OUT,
    output logic             DONE_FLAG_OUT
);
    logic [7:0]  ctrl0_q;
    logic [7:0]  ctrl1_q;
    logic [7:0]  res_high_q;
    logic [7:0]  res_low_q;
    logic        done_flag_q;
    sac_state_t  state_q;
    logic [3:0]  period_q;
    logic [9:0]  sar_q;
    logic [9:0]  trial_q;
    logic        tick;
    logic [11:0] aw_addr_q;
    logic        aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        w_have_q;
    logic        wr_fire;
    logic        wr_c0;
    logic        go_set;
    logic        go_clear;
    logic        finish;
    logic [7:0]  wr_byte;

    // analog enables per port code, bit n is input n
    function automatic logic [7:0] pins_of(input logic [3:0] code);
        case (code)
            4'h0, 4'h1, 4'h8: pins_of = 8'hFF;
            4'h2, 4'h3:       pins_of = 8'h1F;
            4'h4, 4'h5:       pins_of = 8'h0B;
            4'h9, 4'hA, 4'hB: pins_of = 8'h3F;
            4'hC:             pins_of = 8'h1F;
            4'hD:             pins_of = 8'h0F;
            4'hE:             pins_of = 8'h01;
            4'hF:             pins_of = 8'h0D;
            default:          pins_of = 8'h00;
        endcase
    endfunction

    // bit 0: positive ref from input 3, bit 1: negative ref from input 2
    function automatic logic [1:0] refs_of(input logic [3:0] code);
        case (code)
            4'h1, 4'h3, 4'h5, 4'hA:       refs_of = 2'h1;
            4'h8, 4'hB, 4'hC, 4'hD, 4'hF: refs_of = 2'h3;
            default:                      refs_of = 2'h0;
        endcase
    endfunction

    // comparator is read directly: it only follows the registered dac code
    // against a frozen sample, so it settles within a cycle; a two-flop
    // synchroniser would leave no room to resolve a bit in a two-clock period

    // bit period source follows the combined clock code
    sac_tick_gen u_tick
    (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .ce_in    (CE_IN),
        .run_in   (state_q != SAC_IDLE),
        .sel_in   ({ctrl1_q[`SAC_C1_CLKHI],
                    ctrl0_q[`SAC_C0_CLKLO_LSB+1:`SAC_C0_CLKLO_LSB]}),
        .tick_out (tick)
    );

    // write channel: address and data taken in either order
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            BVALID_OUT <= 1'b0;
        end
        else if (CE_IN)
        begin
            if (AWVALID_IN && AWREADY_OUT)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= AWADDR_IN;
            end
            if (WVALID_IN && WREADY_OUT)
            begin
                w_have_q <= 1'b1;
                w_data_q <= WDATA_IN;
                w_strb_q <= WSTRB_IN;
            end
            if (wr_fire)
            begin
                aw_have_q  <= 1'b0;
                w_have_q   <= 1'b0;
                BVALID_OUT <= 1'b1;
            end
            else if (BVALID_OUT && BREADY_IN)
                BVALID_OUT <= 1'b0;
        end
    end

    assign AWREADY_OUT = !aw_have_q && !BVALID_OUT;
    assign WREADY_OUT  = !w_have_q && !BVALID_OUT;
    assign BRESP_OUT   = 2'h0;
    assign wr_fire     = aw_have_q && w_have_q && !BVALID_OUT;
    assign wr_byte     = w_strb_q[0] ? w_data_q[7:0] : 8'h00;
    assign wr_c0       = wr_fire && w_strb_q[0]
                         && aw_addr_q[11:2] == `SAC_OFS_CTRL0 >> 2;
    assign go_set      = wr_c0 && wr_byte[`SAC_C0_GO]
                         && wr_byte[`SAC_C0_POWER]
                         && ctrl0_q[`SAC_C0_POWER]
                         && state_q == SAC_IDLE;
    assign go_clear    = wr_c0 && !wr_byte[`SAC_C0_GO];
    assign finish      = state_q == SAC_CONV && tick
                         && period_q == `SAC_CONV_PERIODS - 4'h1;

    // control registers; go is owned by hardware apart from writes
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            ctrl0_q <= `SAC_CTRL0_RST;
            ctrl1_q <= `SAC_CTRL1_RST;
        end
        else if (CE_IN)
        begin
            if (wr_c0)
                ctrl0_q <= (wr_byte & `SAC_C0_WMASK & 8'hFB)
                         | {5'h00, go_set || (ctrl0_q[`SAC_C0_GO]
                            && !go_clear && !finish
                            && wr_byte[`SAC_C0_POWER]), 2'h0};
            else if (finish || !ctrl0_q[`SAC_C0_POWER])
                ctrl0_q[`SAC_C0_GO] <= 1'b0;
            if (wr_fire && w_strb_q[0]
                && aw_addr_q[11:2] == `SAC_OFS_CTRL1 >> 2)
                ctrl1_q <= wr_byte & `SAC_C1_WMASK;
        end
    end

    // conversion sequencer: twelve bit periods, then two-period hold-off
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            state_q  <= SAC_IDLE;
            period_q <= 4'h0;
            sar_q    <= 10'h000;
            trial_q  <= 10'h200;
        end
        else if (CE_IN)
        begin
            case (state_q)
                SAC_IDLE:
                    if (go_set)
                    begin
                        state_q  <= SAC_CONV;
                        period_q <= 4'h0;
                        sar_q    <= 10'h000;
                        trial_q  <= 10'h200;
                    end
                SAC_CONV:
                    if (go_clear || !ctrl0_q[`SAC_C0_POWER]
                        || (wr_c0 && !wr_byte[`SAC_C0_POWER]))
                    begin
                        state_q  <= SAC_HOLD;
                        period_q <= 4'h0;
                    end
                    else if (tick)
                    begin
                        // periods 1..10 resolve one bit each, msb first
                        if (period_q >= 4'h1 && period_q <= 4'hA)
                        begin
                            if (!CMP_HIGH_IN)
                                sar_q <= sar_q | trial_q;
                            trial_q <= trial_q >> 1;
                        end
                        if (finish)
                        begin
                            state_q  <= SAC_HOLD;
                            period_q <= 4'h0;
                        end
                        else
                            period_q <= period_q + 4'h1;
                    end
                SAC_HOLD:
                    if (tick)
                    begin
                        if (period_q == `SAC_HOLD_PERIODS - 4'h1)
                        begin
                            state_q  <= SAC_IDLE;
                            period_q <= 4'h0;
                        end
                        else
                            period_q <= period_q + 4'h1;
                    end
                default:
                    state_q <= SAC_IDLE;
            endcase
        end
    end

    // result pair has no reset so power-on leaves it alone; also writable
    always_ff @(posedge CLK_IN)
    begin
        if (CE_IN)
        begin
            if (finish)
            begin
                if (ctrl1_q[`SAC_C1_JUSTIFY])
                begin
                    res_high_q <= {6'h00, sar_q[9:8] | trial_q[9:8]
                                   & {2{!CMP_HIGH_IN}}};
                    res_low_q  <= sar_q[7:0]
                                | (trial_q[7:0] & {8{!CMP_HIGH_IN}});
                end
                else
                begin
                    res_high_q <= sar_q[9:2]
                                | (trial_q[9:2] & {8{!CMP_HIGH_IN}});
                    res_low_q  <= {sar_q[1:0]
                                | (trial_q[1:0] & {2{!CMP_HIGH_IN}}), 6'h00};
                end
            end
            else if (wr_fire && w_strb_q[0])
            begin
                if (aw_addr_q[11:2] == `SAC_OFS_RES_HIGH >> 2)
                    res_high_q <= wr_byte;
                if (aw_addr_q[11:2] == `SAC_OFS_RES_LOW >> 2)
                    res_low_q <= wr_byte;
            end
        end
    end

    // done flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            done_flag_q <= 1'b0;
        else if (CE_IN)
        begin
            if (finish)
                done_flag_q <= 1'b1;
            else if (wr_fire && w_strb_q[0] && !wr_byte[0]
                     && aw_addr_q[11:2] == `SAC_OFS_STATUS >> 2)
                done_flag_q <= 1'b0;
        end
    end

    // read channel, one cycle after the address is taken
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            RVALID_OUT <= 1'b0;
            RDATA_OUT  <= 32'h0000_0000;
            RRESP_OUT  <= 2'h0;
        end
        else if (CE_IN)
        begin
            if (ARVALID_IN && ARREADY_OUT)
            begin
                RVALID_OUT <= 1'b1;
                RRESP_OUT  <= 2'h0;
                case (ARADDR_IN)
                    `SAC_OFS_CTRL0:    RDATA_OUT <= {24'h0, ctrl0_q};
                    `SAC_OFS_CTRL1:    RDATA_OUT <= {24'h0, ctrl1_q};
                    `SAC_OFS_RES_HIGH: RDATA_OUT <= {24'h0, res_high_q};
                    `SAC_OFS_RES_LOW:  RDATA_OUT <= {24'h0, res_low_q};
                    `SAC_OFS_STATUS:   RDATA_OUT <= {30'h0,
                                         state_q != SAC_IDLE, done_flag_q};
                    default:
                    begin
                        RDATA_OUT <= 32'h0000_0000;
                        RRESP_OUT <= 2'h2; // unmapped gives slave error
                    end
                endcase
            end
            else if (RVALID_OUT && RREADY_IN)
                RVALID_OUT <= 1'b0;
        end
    end

    assign ARREADY_OUT = !RVALID_OUT;

    // analog side controls, all registered
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            DAC_CODE_OUT    <= 10'h000;
            SAMPLE_HOLD_OUT <= 1'b0;
            CHANNEL_OUT     <= 3'h0;
            ANALOG_PINS_OUT <= 8'hFF;
            REF_SEL_OUT     <= 2'h0;
            POWER_OUT       <= 1'b0;
            DONE_FLAG_OUT   <= 1'b0;
        end
        else if (CE_IN)
        begin
            DAC_CODE_OUT    <= sar_q | trial_q;
            SAMPLE_HOLD_OUT <= state_q == SAC_CONV;
            CHANNEL_OUT     <= ctrl0_q[5:3];
            ANALOG_PINS_OUT <= pins_of(ctrl1_q[3:0]);
            REF_SEL_OUT     <= refs_of(ctrl1_q[3:0]);
            POWER_OUT       <= ctrl0_q[`SAC_C0_POWER];
            DONE_FLAG_OUT   <= done_flag_q;
        end
    end
endmodule

// file: design/sac_map.svh
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// register byte addresses on the register bus
`define SAC_OFS_CTRL0      12'h000
`define SAC_OFS_CTRL1      12'h004
`define SAC_OFS_RES_HIGH   12'h008
`define SAC_OFS_RES_LOW    12'h00C
`define SAC_OFS_STATUS     12'h010
`define SAC_OFS_SAMPLE     12'h014

// control register 0 fields
`define SAC_C0_POWER       0
`define SAC_C0_GO          2
`define SAC_C0_CHAN_LSB    3
`define SAC_C0_CLKLO_LSB   6
`define SAC_C0_WMASK       8'hFD

// control register 1 fields
`define SAC_C1_JUSTIFY     7
`define SAC_C1_CLKHI       6
`define SAC_C1_WMASK       8'hCF

// reset values
`define SAC_CTRL0_RST      8'h00
`define SAC_CTRL1_RST      8'h00

// timing in bit periods
`define SAC_CONV_PERIODS   4'hC
`define SAC_HOLD_PERIODS   4'h2

// internal rc bit period, 4 us at 50 MHz
`define SAC_RC_PERIOD_NS   4000
`define SAC_CLK_PERIOD_NS  20
`define SAC_RC_DIV_CYCLES  (`SAC_RC_PERIOD_NS / `SAC_CLK_PERIOD_NS)

`endif

// file: design/sac_pkg.sv
package sac_pkg;
    typedef enum logic [1:0]
    {
        SAC_IDLE,
        SAC_CONV,
        SAC_HOLD
    } sac_state_t;
endpackage

// file: design/sac_tick_gen.sv
`include "sac_map.svh"

// bit period tick generator, divides the system clock by the selected code
module sac_tick_gen
    import sac_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    input  wire logic       run_in,
    input  wire logic [2:0] sel_in,
    output logic            tick_out
);
    logic [7:0] cnt_q;
    logic [7:0] limit;

    // terminal count per code; x11 runs from the slow internal rc period
    always_comb
    begin
        case (sel_in)
            3'h0:    limit = 8'h01;
            3'h1:    limit = 8'h07;
            3'h2:    limit = 8'h1F;
            3'h4:    limit = 8'h03;
            3'h5:    limit = 8'h0F;
            3'h6:    limit = 8'h3F;
            default: limit = 8'(`SAC_RC_DIV_CYCLES - 1);
        endcase
    end

    // counter restarts whenever the sequencer is idle so periods align
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            cnt_q <= 8'h00;
        else if (ce_in)
        begin
            if (!run_in || cnt_q >= limit)
                cnt_q <= 8'h00;
            else
                cnt_q <= cnt_q + 8'h01;
        end
    end

    assign tick_out = run_in && (cnt_q >= limit);
endmodule

// file: verification/sac_ctrl_checker.sv
module sac_ctrl_checker
(
    input wire logic        CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic        CE_IN,
    input wire logic [11:0] ARADDR_IN,
    input wire logic        ARVALID_IN,
    input wire logic        ARREADY_OUT,
    input wire logic [31:0] RDATA_OUT,
    input wire logic        RVALID_OUT,
    input wire logic        SAMPLE_HOLD_OUT,
    input wire logic        POWER_OUT,
    input wire logic        DONE_FLAG_OUT,
    input wire logic [7:0]  ANALOG_PINS_OUT,
    input wire logic [1:0]  REF_SEL_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] ar_q;
    logic [11:0] cnt_q;
    logic        sh_q;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // address of the read being answered, stable while rvalid
    always_ff @(posedge CLK_IN)
        if (ARVALID_IN && ARREADY_OUT) ar_q <= ARADDR_IN;
    // cycles the sample stays disconnected; an abort raises done only when it lands on the final bit-period tick
    always_ff @(posedge CLK_IN)
    begin
        sh_q <= SAMPLE_HOLD_OUT;
        if (SAMPLE_HOLD_OUT && !sh_q) cnt_q <= 12'h001;
        else if (SAMPLE_HOLD_OUT) cnt_q <= cnt_q + 12'h001;
    end
    sequence s_hold_low;
        !SAMPLE_HOLD_OUT [*4];
    endsequence
    a_hold_off_gap: assert property ($fell(SAMPLE_HOLD_OUT) |-> s_hold_low)
        else $error("sample reconnected too soon");
    a_start_powered: assert property ($rose(SAMPLE_HOLD_OUT) |-> POWER_OUT && $past(POWER_OUT))
        else $error("conversion without power");
    a_off_is_idle: assert property (!POWER_OUT && !$past(POWER_OUT) |-> !SAMPLE_HOLD_OUT)
        else $error("converting while off");
    a_done_at_end: assert property ($rose(DONE_FLAG_OUT) |-> !SAMPLE_HOLD_OUT && ($past(SAMPLE_HOLD_OUT) || $past(SAMPLE_HOLD_OUT, 2)))
        else $error("done not tied to end");
    a_conv_length: assert property ($rose(DONE_FLAG_OUT) |-> cnt_q inside {[12'h016:12'h962]})
        else $error("conversion length wrong");
    a_reset_state: assert property (disable iff (1'b0) !RST_N_IN && CE_IN |=> ANALOG_PINS_OUT == 8'hFF && !POWER_OUT && !SAMPLE_HOLD_OUT)
        else $error("reset state wrong");
    a_ref_has_pin: assert property (REF_SEL_OUT[1] |-> REF_SEL_OUT[0] && ANALOG_PINS_OUT[0])
        else $error("reference selection wrong");
    a_ctrl0_spare: assert property (RVALID_OUT && ar_q == 12'h000 |-> RDATA_OUT[31:8] == 24'h000000 && !RDATA_OUT[1])
        else $error("control0 spare bit set");
    a_ctrl1_spare: assert property (RVALID_OUT && ar_q == 12'h004 |-> RDATA_OUT[5:4] == 2'h0)
        else $error("control1 spare bits set");
endmodule

// file: verification/sac_cmp_model.sv
module sac_cmp_model
(
    input  wire logic       clk_in,
    input  wire logic       sample_hold_in,
    input  wire logic [9:0] dac_code_in,
    input  wire logic [9:0] level_in,
    output logic            cmp_high_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] held_q;
    // follow the pin while sampling, freeze once disconnected
    always_ff @(posedge clk_in)
        if (!sample_hold_in) held_q <= level_in;
    // high when the held level lies below the trial code
    assign cmp_high_out = (sample_hold_in ? held_q : level_in) < dac_code_in;
endmodule

// file: verification/sac_ctrl_test.sv
`include "sac_map.svh"

module sac_ctrl_test
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [1:0]  rr;
    logic [9:0]  level, e;
    logic [7:0]  prev_lo, c0;
    logic [2:0]  k;
    wire         awready, wready, bvalid, arready, rvalid, cmp, sh, pwr, done;
    wire  [31:0] rdata;
    wire  [1:0]  bresp, rresp, refs;
    wire  [9:0]  dac;
    wire  [2:0]  chan;
    wire  [7:0]  pins;
    int          n_mismatch, n_tests, sh_n, i;
    int          conv_bit_period [8] = '{2, 8, 32, 200, 4, 16, 64, 200};
    logic [7:0]  pin_tab [16] = '{8'hFF, 8'hFF, 8'h1F, 8'h1F, 8'h0B, 8'h0B,
        8'h00, 8'h00, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h1F, 8'h0F, 8'h01, 8'h0D};
    logic [1:0]  ref_tab [16] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0,
        2'h0, 2'h3, 2'h0, 2'h1, 2'h3, 2'h3, 2'h3, 2'h0, 2'h3};

    sac_ctrl dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1),
        .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
        .WDATA_IN(wdata), .WSTRB_IN(4'hF), .WVALID_IN(wvalid),
        .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
        .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
        .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
        .RVALID_OUT(rvalid), .RREADY_IN(rready), .CMP_HIGH_IN(cmp),
        .DAC_CODE_OUT(dac), .SAMPLE_HOLD_OUT(sh), .CHANNEL_OUT(chan),
        .ANALOG_PINS_OUT(pins), .REF_SEL_OUT(refs), .POWER_OUT(pwr),
        .DONE_FLAG_OUT(done));
    sac_cmp_model cmp_u (.clk_in(clk), .sample_hold_in(sh),
        .dac_code_in(dac), .level_in(level), .cmp_high_out(cmp));

    // free-running system clock
    always #10 clk = ~clk;
    // disconnected time of the current conversion
    always @(posedge clk)
        if (sh) sh_n <= sh_n + 1;

    task automatic tally_and_finish;
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // handshakes sampled at the rising edge; return settled at the fall
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic hb;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hb = 1'b0;
        while (!hb)
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            hb = bvalid;
        end
        bready <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        logic hr;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hr = 1'b0;
        while (!hr)
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            hr = rvalid;
            d = rdata;
            r = rresp;
        end
        rready <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] x,
                        input logic [1:0] r);
        rd_reg(a, rd, rr);
        chk({rr, rd}, {r, 24'h000000, x});
    endtask

    // read status until bit b shows v, bounded
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        rd_reg(`SAC_OFS_STATUS, rd, rr);
        while (rd[b] !== v && n < 3000)
        begin
            rd_reg(`SAC_OFS_STATUS, rd, rr);
            n++;
        end
        chk(34'(rd[b]), 34'(v));
    endtask

    // watchdog sized well above the longest sequence of conversions
    initial
    begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end

    initial
    begin
        {clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata, level, sh_n} = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        chk(34'(pins), 34'hFF);
        rchk(`SAC_OFS_CTRL0, `SAC_CTRL0_RST, 2'h0);
        rchk(`SAC_OFS_CTRL1, `SAC_CTRL1_RST, 2'h0);
        wr(`SAC_OFS_CTRL0, 8'hFF);
        rchk(`SAC_OFS_CTRL0, 8'hF9, 2'h0);
        chk(34'(sh), 34'h0);
        wr(`SAC_OFS_CTRL1, 8'hFF);
        rchk(`SAC_OFS_CTRL1, 8'hCF, 2'h0);
        wr(`SAC_OFS_SAMPLE, 8'h5A);
        rchk(`SAC_OFS_SAMPLE, 8'h00, 2'h2);
        for (i = 0; i < 16; i++)
        begin
            wr(`SAC_OFS_CTRL1, 8'(i));
            chk(34'(pins), 34'(pin_tab[i]));
            chk(34'(refs), 34'(ref_tab[i]));
        end
        // every clock code, alternating result layout
        for (i = 0; i < 8; i++)
        begin
            k = i[2:0];
            c0 = {k[1:0], k, 3'b001};
            e = 10'h2A5 + 10'(i * 61);
            wr(`SAC_OFS_CTRL1, {k[0], k[2], 6'h00});
            wr(`SAC_OFS_CTRL0, c0);
            chk(34'(chan), 34'(k));
            level <= e;
            repeat (20) @(posedge clk);
            sh_n <= 0;
            wr(`SAC_OFS_CTRL0, c0 | 8'h04);
            rchk(`SAC_OFS_CTRL0, c0 | 8'h04, 2'h0);
            level <= ~e;
            poll(0, 1'b1);
            chk(34'(done), 34'h1);
            rchk(`SAC_OFS_CTRL0, c0, 2'h0);
            chk(34'(sh_n >= 12 * conv_bit_period[i] - 2 && sh_n <= 12 * conv_bit_period[i] + 2),
                34'h1);
            rchk(`SAC_OFS_RES_HIGH, k[0] ? {6'h00, e[9:8]} : e[9:2],
                 2'h0);
            rchk(`SAC_OFS_RES_LOW, k[0] ? e[7:0] : {e[1:0], 6'h00},
                 2'h0);
            poll(1, 1'b0);
            wr(`SAC_OFS_STATUS, 8'h00);
            rchk(`SAC_OFS_STATUS, 8'h00, 2'h0);
        end
        // abort mid-conversion, then a go inside the hold-off
        prev_lo = e[7:0];
        level <= 10'h155;
        repeat (20) @(posedge clk);
        wr(`SAC_OFS_CTRL0, 8'hFD);
        repeat (50) @(posedge clk);
        wr(`SAC_OFS_CTRL0, 8'hF9);
        wr(`SAC_OFS_CTRL0, 8'hFD);
        chk(34'(sh), 34'h0);
        rchk(`SAC_OFS_CTRL0, 8'hF9, 2'h0);
        rchk(`SAC_OFS_RES_LOW, prev_lo, 2'h0);
        poll(1, 1'b0);
        // reset during a conversion with every pin digital
        wr(`SAC_OFS_CTRL1, 8'hC6);
        chk(34'(pins), 34'h00);
        wr(`SAC_OFS_CTRL0, 8'hFD);
        repeat (30) @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(34'(pins), 34'hFF);
        chk(34'({sh, pwr}), 34'h0);
        rchk(`SAC_OFS_CTRL0, 8'h00, 2'h0);
        rchk(`SAC_OFS_CTRL1, 8'h00, 2'h0);
        rchk(`SAC_OFS_RES_LOW, prev_lo, 2'h0);
        tally_and_finish();
    end
endmodule

bind sac_ctrl sac_ctrl_checker chk_u (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
    .CE_IN(CE_IN), .ARADDR_IN(ARADDR_IN), .ARVALID_IN(ARVALID_IN),
    .ARREADY_OUT(ARREADY_OUT), .RDATA_OUT(RDATA_OUT),
    .RVALID_OUT(RVALID_OUT), .SAMPLE_HOLD_OUT(SAMPLE_HOLD_OUT),
    .POWER_OUT(POWER_OUT), .DONE_FLAG_OUT(DONE_FLAG_OUT),
    .ANALOG_PINS_OUT(ANALOG_PINS_OUT), .REF_SEL_OUT(REF_SEL_OUT));
